/* bench/bb_source.sv */
// Baseband sample source that feeds the parallel port of the upconverter.
`timescale 1ns/10ps
`default_nettype none

module bb_source
  import upconv_pkg::*;
(
  input wire logic i_sample_clk,
  input wire logic i_rstn,
  input wire logic i_gate_req,
  output var logic [PAR_W-1:0] o_data,
  output var logic o_gate,
  output var int o_sent
);

  // ==========================================================================
  // Word source
  // ==========================================================================
  // Idle data is inverted each period so a port that samples it is caught.
  always @(posedge i_sample_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data <= '0;
      o_gate <= 1'b0;
      o_sent <= 0;
    end else begin
      o_gate <= i_gate_req;
      if (i_gate_req) begin
        o_data <= PAR_W'($urandom);
        o_sent <= (o_gate ? o_sent : 0) + 1;
      end else begin
        o_data <= ~o_data;
      end
    end
  end

endmodule : bb_source
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench of the upconverter datapath.
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import upconv_pkg::*;
;
  logic i_clk_sys;
  logic i_rstn;
  bus_req_t bus;
  logic [31:0] o_rdata;
  pins_t pins;
  logic o_sample_clk;
  logic [DAC_W-1:0] o_dac;
  logic [PAR_W-1:0] src_data;
  logic src_gate;
  logic gate_req;
  logic output_shift_keying;
  logic gp;
  int src_sent;
  int err_count;
  int checks;
  int hi;
  int lo;
  int n;
  int seed;
  logic [31:0] rv;
  logic [31:0] mdl [0:4];
  logic [7:0] addrs [0:5];

  assign pins = '{data: src_data, gate: src_gate, output_shift_keying: output_shift_keying};

  upconv_datapath upconv_datapath_i (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_bus(bus),
    .o_rdata(o_rdata),
    .i_pins(pins),
    .o_sample_clk(o_sample_clk),
    .o_dac(o_dac)
  );

  bb_source bb_source_i (
    .i_sample_clk(o_sample_clk),
    .i_rstn(i_rstn),
    .i_gate_req(gate_req),
    .o_data(src_data),
    .o_gate(src_gate),
    .o_sent(src_sent)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic mreset();
    mdl = '{32'h0, 32'(TUNE_RESET), 32'(ASF_RESET), 32'(OSK_STEP_RESET),
            32'(RATE_MIN)};
  endtask : mreset

  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
    @(posedge i_clk_sys);
    case (a)
      ADDR_CONTROL_FUNCTION_REGISTER_ONE: if (d[1:0] != 2'b11) mdl[0] = d & 32'h3F;
      ADDR_TUNE: mdl[1] = d & 32'hFFFF;
      ADDR_ASF: mdl[2] = d & 32'h3FFF;
      ADDR_OSK_STEP: mdl[3] = d & 32'h3FFF;
      ADDR_RATE: mdl[4] = (d[7:0] < RATE_MIN) ? 32'(RATE_MIN) : d & 32'hFF;
      default: ;
    endcase
  endtask : bw

  task automatic br(input logic [7:0] a, output logic [31:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    #1;
    d = o_rdata;
    @(posedge i_clk_sys);
  endtask : br

  task automatic sweep();
    for (int i = 0; i < 6; i++) begin
      br(addrs[i], rv);
      chk("register", (i < 5) ? mdl[i] : 32'h0, rv);
    end
  endtask : sweep

  task automatic rise();
    bit seen_low;
    seen_low = 1'b0;
    for (int k = 0; k < 300; k++) begin
      @(posedge i_clk_sys);
      #1;
      if (o_sample_clk === 1'b0) seen_low = 1'b1;
      else if (seen_low) return;
    end
    err_count++;
  endtask : rise

  task automatic period(output int h, output int l);
    int st;
    st = 0;
    h = 0;
    l = 0;
    for (int k = 0; k < 300; k++) begin
      @(posedge i_clk_sys);
      #1;
      case (st)
        0: if (o_sample_clk === 1'b0) st = 1;
        1: if (o_sample_clk === 1'b1) begin
          st = 2;
          h = 1;
        end
        2: if (o_sample_clk === 1'b1) begin
          h++;
        end else begin
          st = 3;
          l = 1;
        end
        default: if (o_sample_clk === 1'b0) l++; else return;
      endcase
    end
  endtask : period

  // Seven words then a drop: the odd trailing I must be discarded.
  task automatic burst(input bit tone);
    logic e;
    gp = 1'b0;
    gate_req <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      if (k == 7) gate_req <= 1'b0;
      rise();
      n = src_sent;
      br(ADDR_STATUS, rv);
      e = (!tone && gp) ? (src_gate ? ~n[0] : n[0]) : 1'b0;
      chk("pair", 32'(e), 32'(rv[STAT_PAIR_BIT]));
      chk("gate", 32'(gp), 32'(rv[STAT_GATE_BIT]));
      gp = src_gate;
    end
  endtask : burst

  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  initial begin
    i_clk_sys = 1'b0;
    forever #(CLK_PERIOD_NS / 2) i_clk_sys = ~i_clk_sys;
  end

  initial begin
    #(CLK_PERIOD_NS * 20000);
    err_count++;
    give_verdict();
  end

  initial begin
    i_rstn = 1'b0;
    bus = '0;
    gate_req = 1'b0;
    output_shift_keying = 1'b0;
    err_count = 0;
    checks = 0;
    seed = $urandom(18);
    addrs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    mreset();
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("dac", 32'h2000, 32'(o_dac));
    chk("sclk", 32'h0, 32'(o_sample_clk));
    chk("rdata", 32'h0, o_rdata);
    @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    @(posedge i_clk_sys);
    sweep();
    for (int i = 0; i < 20; i++) begin
      rv = $urandom;
      n = $urandom % 6;
      if (addrs[n] == ADDR_RATE) rv = rv % 16;
      bw(addrs[n], rv);
    end
    sweep();
    bw(ADDR_CONTROL_FUNCTION_REGISTER_ONE, 32'h1);
    bw(ADDR_CONTROL_FUNCTION_REGISTER_ONE, 32'h3);
    bw(ADDR_RATE, 32'h1);
    sweep();
    bw(ADDR_RATE, 32'h5);
    period(hi, lo);
    chk("high", 32'h5, 32'(hi));
    chk("low", 32'h5, 32'(lo));
    bw(ADDR_CONTROL_FUNCTION_REGISTER_ONE, 32'h0);
    bw(ADDR_RATE, 32'h4);
    period(hi, lo);
    chk("period", 32'h8, 32'(hi + lo));
    burst(1'b0);
    bw(ADDR_CONTROL_FUNCTION_REGISTER_ONE, 32'(MODE_TONE));
    burst(1'b1);
    bw(ADDR_OSK_STEP, 32'h1);
    bw(ADDR_ASF, 32'h20);
    bw(ADDR_CONTROL_FUNCTION_REGISTER_ONE, 32'(MODE_TONE) | 32'h20);
    output_shift_keying <= 1'b1;
    repeat (60) @(posedge i_clk_sys);
    br(ADDR_STATUS, rv);
    chk("amp up", 32'h20, rv & 32'h3FFF);
    output_shift_keying <= 1'b0;
    repeat (60) @(posedge i_clk_sys);
    br(ADDR_STATUS, rv);
    chk("amp down", 32'h0, rv & 32'h3FFF);
    bw(ADDR_ASF, 32'h13);
    bw(ADDR_CONTROL_FUNCTION_REGISTER_ONE, 32'(MODE_TONE) | 32'h18);
    repeat (8) @(posedge i_clk_sys);
    br(ADDR_STATUS, rv);
    chk("amp", 32'h13, rv & 32'h3FFF);
    bw(ADDR_ASF, 32'h0);
    repeat (20) @(posedge i_clk_sys);
    for (int i = 0; i < 16; i++) begin
      @(posedge i_clk_sys);
      #1;
      chk("dac", 32'h2000, 32'(o_dac));
    end
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    mreset();
    @(posedge i_clk_sys);
    br(ADDR_CONTROL_FUNCTION_REGISTER_ONE, rv);
    chk("mode", 32'h0, rv);
    br(ADDR_STATUS, rv);
    chk("pair", 32'h0, 32'(rv[STAT_PAIR_BIT]));
    give_verdict();
  end

endmodule : tb_top
`default_nettype wire

/* hw/upconv_datapath.sv */
// Mode control, sample capture and output datapath of the upconverter.
//
// What this block does
// - Three modes; quadrature is the reset mode.
// - Mode field of control register selects mode.
// - Parallel port takes I then Q words.
// - One I and one Q form a sample.
// - Oscillator cosine/sine modulate I/Q, products summed.
// - Modulated stream: inverse sinc, scaling, converter.
// - Inverse sinc selectable in every mode.
// - Dual serial streams carry 16-bit words.
// - Serial words shifted into parallel words.
// - Sample clock is bit clock in serial mode.
// - Interpolating mode uses only the I path.
// - Sample clock runs in interpolating mode.
// - Interpolating mode holds each I word then filters, no translation.
// - Tone mode disables paths; oscillator uses tuning word.
// - Tone mode routes cosine or sine output.
// - Tone output scaled before inverse sinc.
// - Shift keying ramps amplitude between zero, preset.
// - Each active clock edge captures one word; in serial mode one bit per stream.
// - Port data ignored while transmit gate false.
// - First word after gate rises is I.
`timescale 1ns/10ps
`default_nettype none

module upconv_datapath
  import upconv_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire bus_req_t i_bus,
  output logic [31:0] o_rdata,
  input wire pins_t i_pins,
  output logic o_sample_clk,
  output logic [DAC_W-1:0] o_dac
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    cfr_t cfr;
    logic [15:0] tune;
    logic [13:0] amplitude_scale_factor;
    logic [13:0] step;
    logic [7:0] rate;
    logic [13:0] amp;
    logic pclk;
    logic [7:0] cnt;
    pins_t d1;
    pins_t d2;
    pins_t d3;
    pins_t pin;
    logic pair;
    logic [3:0] bits;
    logic [SER_W-1:0] shi;
    logic [SER_W-1:0] shq;
    logic signed [PAR_W-1:0] i_word;
    logic signed [PAR_W-1:0] q_word;
    logic smp_v;
    logic signed [PAR_W-1:0] prev_i;
    logic signed [PAR_W-1:0] prev_q;
    logic signed [PAR_W-1:0] acc_i;
    logic signed [PAR_W-1:0] acc_q;
    logic [15:0] phase;
    logic signed [13:0] x0;
    logic signed [13:0] x1;
    logic signed [13:0] x2;
    logic [DAC_W-1:0] dac;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // ==========================================================================
  // Arithmetic helpers
  // ==========================================================================
  // A triangle stands in for the sinusoid; it keeps the table out of logic.
  function automatic logic signed [13:0] wave(input logic [15:0] ph);
    logic [13:0] f;
    logic signed [13:0] v;
    f = ph[14] ? ~ph[13:0] : ph[13:0];
    v = $signed(f ^ 14'h2000);
    return ph[15] ? ~v : v;
  endfunction : wave

  function automatic logic signed [13:0] scale(
    input logic signed [13:0] x,
    input logic [13:0] a
  );
    logic signed [28:0] p;
    p = 29'(x * $signed({1'b0, a}));
    return p[27:14];
  endfunction : scale

  function automatic logic signed [13:0] sat(input logic signed [19:0] t);
    logic signed [15:0] y;
    y = t[19:4];
    if (y > 16'sh1FFF) begin
      return 14'sh1FFF;
    end else if (y < -16'sh2000) begin
      return -14'sh2000;
    end
    return y[13:0];
  endfunction : sat

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic cap;
  logic quad;
  logic signed [13:0] ii;
  logic signed [13:0] qq;
  logic signed [13:0] cosv;
  logic signed [13:0] sinv;
  logic signed [28:0] msum;
  logic signed [13:0] pre;
  logic signed [19:0] tap;
  logic signed [13:0] filt;
  logic signed [13:0] outv;
  logic [13:0] target;
  cfr_t wcfr;
  pins_t pin_now;

  always_comb begin
    next_s = s;
    next_s.smp_v = 1'b0;
    wcfr = cfr_t'(i_bus.wdata[5:0]);

    // Register port; code 3 of the mode field is refused.
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        ADDR_CONTROL_FUNCTION_REGISTER_ONE: begin
          if (i_bus.wdata[CFR_MODE_LSB +: 2] != 2'h3) begin
            next_s.cfr = wcfr;
          end
        end
        ADDR_TUNE: next_s.tune = i_bus.wdata[15:0];
        ADDR_ASF: next_s.amplitude_scale_factor = i_bus.wdata[13:0];
        ADDR_OSK_STEP: next_s.step = i_bus.wdata[13:0];
        ADDR_RATE: begin
          next_s.rate = (i_bus.wdata[7:0] < RATE_MIN) ?
                        RATE_MIN : i_bus.wdata[7:0];
        end
        default: ;
      endcase
    end
    next_s.rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        ADDR_CONTROL_FUNCTION_REGISTER_ONE: next_s.rdata = {26'h0, s.cfr};
        ADDR_TUNE: next_s.rdata = {16'h0, s.tune};
        ADDR_ASF: next_s.rdata = {18'h0, s.amplitude_scale_factor};
        ADDR_OSK_STEP: next_s.rdata = {18'h0, s.step};
        ADDR_RATE: next_s.rdata = {24'h0, s.rate};
        ADDR_STATUS: begin
          next_s.rdata[13:0] = s.amp;
          next_s.rdata[STAT_PAIR_BIT] = s.pair;
          next_s.rdata[STAT_GATE_BIT] = s.pin.gate;
        end
        default: ;
      endcase
    end

    // Pin synchroniser: a value counts once stages two and three agree.
    next_s.d1 = i_pins;
    next_s.d2 = s.d1;
    next_s.d3 = s.d2;
    if (s.d2 == s.d3) begin
      next_s.pin = s.d3;
    end
    // Capture reads the copy as it is agreed in this very cycle; the held
    // copy would lag it by one more system clock cycle, at every rate.
    pin_now = next_s.pin;

    // Sample clock divider; it runs in every mode, as the host's timebase.
    cap = 1'b0;
    if (s.cnt >= s.rate - 8'h01) begin
      next_s.cnt = 8'h00;
      next_s.pclk = ~s.pclk;
      // Host updates after our rising edge, so the synchronised copy is
      // taken at our falling edge when it has long settled.
      cap = s.pclk;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
    // A new rate restarts the phase so no half period comes out short.
    if (i_bus.wr && i_bus.addr == ADDR_RATE) begin
      next_s.cnt = 8'h00;
    end

    quad = (s.cfr.mode == MODE_QUAD);
    if (!pin_now.gate) begin
      next_s.pair = 1'b0;
      next_s.bits = 4'h0;
    end else if (cap) begin
      unique case (s.cfr.mode)
        MODE_QUAD: begin
          if (s.cfr.dual) begin
            next_s.shi = {s.shi[SER_W-2:0], pin_now.data[0]};
            next_s.shq = {s.shq[SER_W-2:0], pin_now.data[1]};
            next_s.bits = s.bits + 4'h1;
            if (s.bits == SER_LAST) begin
              next_s.i_word = {s.shi[SER_W-2:0], pin_now.data[0], 2'b00};
              next_s.q_word = {s.shq[SER_W-2:0], pin_now.data[1], 2'b00};
              next_s.smp_v = 1'b1;
            end
          end else if (!s.pair) begin
            next_s.i_word = pin_now.data;
            next_s.pair = 1'b1;
          end else begin
            next_s.q_word = pin_now.data;
            next_s.pair = 1'b0;
            next_s.smp_v = 1'b1;
          end
        end
        MODE_INTERP: begin
          next_s.i_word = pin_now.data;
          next_s.smp_v = 1'b1;
        end
        MODE_TONE: ;
        default: ;
      endcase
    end

    // Comb and integrator both step at the word rate, only when smp_v is set.
    if (s.smp_v) begin
      next_s.prev_i = s.i_word;
      next_s.prev_q = s.q_word;
      next_s.acc_i = s.acc_i + (s.i_word - s.prev_i);
      next_s.acc_q = s.acc_q + (s.q_word - s.prev_q);
    end

    // Shift keying ramp toward the preset or toward zero.
    target = s.pin.output_shift_keying ? s.amplitude_scale_factor : 14'h0000;
    if (!s.cfr.osk_en) begin
      next_s.amp = s.amplitude_scale_factor;
    end else if (s.amp < target) begin
      next_s.amp = (target - s.amp > s.step) ? s.amp + s.step : target;
    end else if (s.amp > target) begin
      next_s.amp = (s.amp - target > s.step) ? s.amp - s.step : target;
    end

    // Oscillator and mode routing.
    next_s.phase = s.phase + s.tune;
    cosv = wave(s.phase + 16'h4000);
    sinv = wave(s.phase);
    ii = s.acc_i[PAR_W-1:4];
    qq = s.acc_q[PAR_W-1:4];
    msum = 29'(ii * cosv) + 29'(qq * sinv);
    unique case (s.cfr.mode)
      MODE_QUAD: pre = msum[27:14];
      MODE_INTERP: pre = ii;
      MODE_TONE: pre = scale(s.cfr.sine_sel ? sinv : cosv, s.amp);
      default: pre = '0;
    endcase

    // Three-tap inverse sinc, gain 16 then shifted back down.
    next_s.x0 = pre;
    next_s.x1 = s.x0;
    next_s.x2 = s.x1;
    tap = (20'(s.x1) <<< 4) + (20'(s.x1) <<< 1) - 20'(s.x0) - 20'(s.x2);
    filt = s.cfr.sinc_en ? sat(tap) : s.x1;
    outv = (s.cfr.mode == MODE_TONE) ? filt : scale(filt, s.amp);
    next_s.dac = outv ^ 14'h2000;

    // Leaving a mode drops the held I/Q words and pair state; the sinc taps x0..x2 keep their old samples.
    if (next_s.cfr.mode != s.cfr.mode || next_s.cfr.dual != s.cfr.dual) begin
      next_s.i_word = '0;
      next_s.q_word = '0;
      next_s.prev_i = '0;
      next_s.prev_q = '0;
      next_s.acc_i = '0;
      next_s.acc_q = '0;
      next_s.pair = 1'b0;
      next_s.bits = 4'h0;
      next_s.smp_v = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
      s.cfr.mode <= MODE_QUAD;
      s.tune <= TUNE_RESET;
      s.amplitude_scale_factor <= ASF_RESET;
      s.amp <= ASF_RESET;
      s.step <= OSK_STEP_RESET;
      s.rate <= RATE_MIN;
      s.dac <= 14'h2000;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_sample_clk = s.pclk;
  assign o_dac = s.dac;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  sequence s_cfr_write;
    i_bus.wr && i_bus.addr == ADDR_CONTROL_FUNCTION_REGISTER_ONE && i_bus.wdata[1:0] != 2'h3;
  endsequence

  sequence s_i_taken;
    cap && pin_now.gate && quad && !s.cfr.dual && !s.pair;
  endsequence

  property p_mode_legal;
    s.cfr.mode != op_mode_t'(2'h3);
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("illegal operating mode held");

  property p_mode_write;
    s_cfr_write |=> s.cfr.mode == $past(i_bus.wdata[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode field write not applied");

  property p_gate_low_pair;
    !pin_now.gate |=> !s.pair && s.bits == 4'h0;
  endproperty
  a_gate_low_pair: assert property (p_gate_low_pair)
    else $error("pairing not reset while gate low");

  property p_ignore;
    cap && !pin_now.gate && next_s.cfr == s.cfr |=>
      $stable(s.i_word) && !s.smp_v;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("data taken while gate low");

  property p_pair;
    s_i_taken ##1 (!s.smp_v)[*1] |-> s.pair || !s.pin.gate ||
      $changed(s.cfr);
  endproperty
  a_pair: assert property (p_pair)
    else $error("I word did not open a pair");

  property p_clk_half;
    $rose(o_sample_clk) |=> o_sample_clk[*3];
  endproperty
  a_clk_half: assert property (p_clk_half)
    else $error("sample clock high phase too short");

  property p_interp_q;
    s.cfr.mode == MODE_INTERP && $past(s.cfr.mode) == MODE_INTERP
      |-> s.q_word == '0 && s.acc_q == '0;
  endproperty
  a_interp_q: assert property (p_interp_q)
    else $error("Q path active in interpolating mode");

  property p_tone_idle;
    s.cfr.mode == MODE_TONE && $past(s.cfr.mode) == MODE_TONE
      |-> s.i_word == '0 && !s.smp_v;
  endproperty
  a_tone_idle: assert property (p_tone_idle)
    else $error("baseband path active in tone mode");

  property p_serial_word;
    cap && pin_now.gate && quad && s.cfr.dual && s.bits == SER_LAST
      && $stable(s.cfr) |=> s.smp_v || $changed(s.cfr);
  endproperty
  a_serial_word: assert property (p_serial_word)
    else $error("serial word not delivered after 16 bits");

  property p_osk_off;
    !s.cfr.osk_en ##1 !s.cfr.osk_en && $stable(s.amplitude_scale_factor) |-> s.amp == s.amplitude_scale_factor;
  endproperty
  a_osk_off: assert property (p_osk_off)
    else $error("amplitude differs from preset without keying");

endmodule : upconv_datapath

`default_nettype wire

/* hw/upconv_pkg.sv */
// Shared types, register map and timing constants of the upconverter datapath.
package upconv_pkg;

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_QUAD,
    MODE_INTERP,
    MODE_TONE
  } op_mode_t;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_CONTROL_FUNCTION_REGISTER_ONE = 8'h00;
  localparam logic [7:0] ADDR_TUNE = 8'h04;
  localparam logic [7:0] ADDR_ASF = 8'h08;
  localparam logic [7:0] ADDR_OSK_STEP = 8'h0C;
  localparam logic [7:0] ADDR_RATE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  localparam int CFR_MODE_LSB = 0;
  localparam int CFR_DUAL_BIT = 2;
  localparam int CFR_SINC_BIT = 3;
  localparam int CFR_SINE_BIT = 4;
  localparam int CFR_OSK_BIT = 5;
  localparam int STAT_PAIR_BIT = 16;
  localparam int STAT_GATE_BIT = 17;

  localparam logic [15:0] TUNE_RESET = 16'h0000;
  localparam logic [13:0] ASF_RESET = 14'h3FFF;
  localparam logic [13:0] OSK_STEP_RESET = 14'h0001;

  // ==========================================================================
  // Widths and timing
  // ==========================================================================
  localparam int PAR_W = 18;
  localparam int SER_W = 16;
  localparam int DAC_W = 14;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] RATE_MIN = 8'(LINK_HALF_CYC);
  localparam logic [3:0] SER_LAST = 4'(SER_W - 1);

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [PAR_W-1:0] data;
    logic gate;
    logic output_shift_keying;
  } pins_t;

  typedef struct packed {
    logic osk_en;
    logic sine_sel;
    logic sinc_en;
    logic dual;
    op_mode_t mode;
  } cfr_t;

endpackage : upconv_pkg
